// ---- design/rairr_pkg.sv ----
// constants for the right adc input routing register bank
// Overview of operation
// - bit 7 of the second right line routing register selects single-ended (0) or fully differential (1) and resets to 0.
// - level codes 0000 to 1000 of the second right line register give 0 dB to -12 dB in -1.5 dB steps and connect the input to the right mixer.
// - level code 1111 of the second right line register disconnects the input, and the field resets to 1111.
// - bit 2 of the second right line register weakly biases the unselected right inputs to common mode when 1 and resets to 0.
// - the low reserved bits (2-0 of the first register, 1-0 of the second) are read-only zeros, and software writes only zeros there.
// - bit 7 of the first left line to right register selects single-ended (0) or fully differential (1) and resets to 0.
// - level codes 0000 to 1000 of the first left line to right register use the same attenuation steps and route the input to the right mixer.
// - level code 1111 of the first left line to right register leaves the input unconnected, and the field resets to 1111.
// - a separate right channel power bit powers the right adc channel up when 1 and down when 0.
package rairr_pkg;
   localparam int unsigned ADR_W  = 8;
   localparam int unsigned DAT_W  = 32;
   localparam int unsigned IDX_W  = 6;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_PWR   = 6'h16;
   localparam logic [5:0] IDX_LINE2 = 6'h17;
   localparam logic [5:0] IDX_LINE1 = 6'h18;
   localparam logic [5:0] IDX_STAT  = 6'h1f;
   // field positions
   localparam int unsigned DIFF_BIT = 7;
   localparam int unsigned LVL_HI   = 6;
   localparam int unsigned LVL_LO   = 3;
   localparam int unsigned BIAS_BIT = 2;
   localparam int unsigned PWR_BIT  = 2;
   // writable masks; everything else reads zero
   localparam logic [7:0] MASK_LINE2 = 8'hfc;
   localparam logic [7:0] MASK_LINE1 = 8'hf8;
   localparam logic [7:0] MASK_PWR   = 8'h04;
   // reset values
   localparam logic [7:0] RST_LINE2 = 8'h78;
   localparam logic [7:0] RST_LINE1 = 8'h78;
   localparam logic [7:0] RST_PWR   = 8'h00;
   // level codes
   localparam logic [3:0] LVL_MAX_ATT = 4'h8;
   localparam logic [3:0] LVL_OFF     = 4'hf;
   localparam int unsigned NUM_ROUTES = 2;
endpackage : rairr_pkg

// ---- design/rairr_route_if.sv ----
// routing register value and its decoded controls for one input
interface rairr_route_if;
   logic [7:0] reg_val;
   logic       diff;
   logic       conn;
   logic [4:0] atten_hdb;
   modport src (output reg_val, input diff, conn, atten_hdb);
   modport dec (input reg_val, output diff, conn, atten_hdb);
endinterface : rairr_route_if

// ---- design/rairr_route_dec.sv ----
// decodes one routing register into registered analog controls
module rairr_route_dec
(
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   rairr_route_if.dec  rt
);
   // attenuation in half-dB units: code times three
   function automatic logic [4:0] hdb(input logic [3:0] c);
      hdb = {1'b0, c} + {c, 1'b0};
   endfunction

   logic [3:0] lvl;
   logic       next_diff;
   logic       next_conn;
   logic [4:0] next_atten;

   assign lvl = rt.reg_val[rairr_pkg::LVL_HI:rairr_pkg::LVL_LO];

   // reserved codes are treated as disconnected to keep the mixer quiet
   always_comb
   begin
      next_diff  = rt.reg_val[rairr_pkg::DIFF_BIT];
      next_conn  = (lvl <= rairr_pkg::LVL_MAX_ATT);
      next_atten = next_conn ? hdb(lvl) : 5'h00;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rt.diff      <= 1'b0;
         rt.conn      <= 1'b0;
         rt.atten_hdb <= 5'h00;
      end
      else
      begin
         rt.diff      <= next_diff;
         rt.conn      <= next_conn;
         rt.atten_hdb <= next_atten;
      end
   end
endmodule // rairr_route_dec

// ---- design/rairr_regs.sv ----
// wishbone register bank steering right adc input routing
module rairr_regs
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        we_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output      logic [31:0] dat_o,
   output      logic        ack_o,
   output      logic        second_right_line_input_diff_o,
   output      logic        second_right_line_input_conn_o,
   output      logic [4:0]  second_right_line_input_atten_o,
   output      logic        first_left_line_input_diff_o,
   output      logic        first_left_line_input_conn_o,
   output      logic [4:0]  first_left_line_input_atten_o,
   output      logic        weak_cm_bias_o,
   output      logic        right_adc_power_o
);
   logic [7:0]  line2_reg;
   logic [7:0]  line1_reg;
   logic [7:0]  pwr_reg;
   logic [7:0]  next_line2;
   logic [7:0]  next_line1;
   logic [7:0]  next_pwr;
   logic        next_ack;
   logic [31:0] next_dat;
   logic        req;
   logic        wr;
   logic [5:0]  idx;

   rairr_route_if rt [rairr_pkg::NUM_ROUTES] ();

   // one cycle request to answer; ack is dropped after one cycle
   assign req = cyc_i & stb_i;
   assign idx = adr_i[7:2];
   // write lands at the edge where the master sees ack
   assign wr  = req & we_i & ack_o & sel_i[0];

   // register write path; reserved bits are masked to zero
   always_comb
   begin
      next_line2 = line2_reg;
      next_line1 = line1_reg;
      next_pwr   = pwr_reg;
      if (wr && idx == rairr_pkg::IDX_LINE2)
         next_line2 = dat_i[7:0] & rairr_pkg::MASK_LINE2;
      if (wr && idx == rairr_pkg::IDX_LINE1)
         next_line1 = dat_i[7:0] & rairr_pkg::MASK_LINE1;
      if (wr && idx == rairr_pkg::IDX_PWR)
         next_pwr = dat_i[7:0] & rairr_pkg::MASK_PWR;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         line2_reg <= rairr_pkg::RST_LINE2;
         line1_reg <= rairr_pkg::RST_LINE1;
         pwr_reg   <= rairr_pkg::RST_PWR;
      end
      else
      begin
         line2_reg <= next_line2;
         line1_reg <= next_line1;
         pwr_reg   <= next_pwr;
      end
   end

   // read mux and ack; unmapped reads answer zero, writes ignored
   always_comb
   begin
      next_ack = req & ~ack_o;
      next_dat = 32'h0000_0000;
      unique case (idx)
         rairr_pkg::IDX_LINE2: next_dat = {24'h00_0000, line2_reg};
         rairr_pkg::IDX_LINE1: next_dat = {24'h00_0000, line1_reg};
         rairr_pkg::IDX_PWR:   next_dat = {24'h00_0000, pwr_reg};
         rairr_pkg::IDX_STAT:  next_dat = {29'h0000_0000,
                                           right_adc_power_o,
                                           first_left_line_input_conn_o,
                                           second_right_line_input_conn_o};
         default:              next_dat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_o <= next_ack;
         dat_o <= next_dat;
      end
   end

   // bias and power follow their bits one cycle later, from flops
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         weak_cm_bias_o    <= 1'b0;
         right_adc_power_o <= 1'b0;
      end
      else
      begin
         weak_cm_bias_o    <= line2_reg[rairr_pkg::BIAS_BIT];
         right_adc_power_o <= pwr_reg[rairr_pkg::PWR_BIT];
      end
   end

   // both routings share one decoder shape
   assign rt[0].reg_val = line2_reg;
   assign rt[1].reg_val = line1_reg;

   generate
      for (genvar g = 0; g < rairr_pkg::NUM_ROUTES; g++)
      begin : g_dec
         rairr_route_dec u_dec
         (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .rt    (rt[g])
         );
      end
   endgenerate

   assign second_right_line_input_diff_o  = rt[0].diff;
   assign second_right_line_input_conn_o  = rt[0].conn;
   assign second_right_line_input_atten_o = rt[0].atten_hdb;
   assign first_left_line_input_diff_o    = rt[1].diff;
   assign first_left_line_input_conn_o    = rt[1].conn;
   assign first_left_line_input_atten_o   = rt[1].atten_hdb;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [3:0] lvl2;
   logic [3:0] lvl1;
   assign lvl2 = line2_reg[rairr_pkg::LVL_HI:rairr_pkg::LVL_LO];
   assign lvl1 = line1_reg[rairr_pkg::LVL_HI:rairr_pkg::LVL_LO];

   AST_RESET_VALUES: assert property (disable iff (1'b0)
      rst_i |=> (line2_reg == 8'h78 && line1_reg == 8'h78
                 && pwr_reg == 8'h00))
      else $error("reset values wrong");
   AST_LINE2_DIFF: assert property (
      wr && idx == 6'h17 |=> ##1 second_right_line_input_diff_o == $past(dat_i[7], 2))
      else $error("second line diff not following write");
   AST_LINE2_CONN: assert property (
      lvl2 <= 4'h8 |=> second_right_line_input_conn_o
         && second_right_line_input_atten_o == 5'($past(lvl2) * 3))
      else $error("second line level decode wrong");
   AST_LINE2_OFF: assert property (
      lvl2 == 4'hf |=> !second_right_line_input_conn_o)
      else $error("second line not disconnected");
   AST_BIAS: assert property (
      wr && idx == 6'h17 |=> ##1 weak_cm_bias_o == $past(dat_i[2], 2))
      else $error("weak bias not following write");
   AST_RESERVED: assert property (
      line2_reg[1:0] == 2'h0 && line1_reg[2:0] == 3'h0)
      else $error("reserved bits not zero");
   AST_RSV_READ: assert property (
      req && !we_i && !ack_o && idx == 6'h18 |=> ack_o && dat_o[2:0] == 3'h0)
      else $error("reserved bits read nonzero");
   AST_LINE1_DIFF: assert property (
      first_left_line_input_diff_o == $past(line1_reg[7]))
      else $error("first line diff wrong");
   AST_LINE1_CONN: assert property (
      lvl1 <= 4'h8 |=> first_left_line_input_conn_o)
      else $error("first line not connected");
   AST_LINE1_OFF: assert property (
      lvl1 == 4'hf |=> !first_left_line_input_conn_o)
      else $error("first line not disconnected");
   AST_POWER: assert property (
      wr && idx == 6'h16 |=> ##1 right_adc_power_o == $past(dat_i[2], 2))
      else $error("power bit not following write");
   AST_ACK_ONE: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   COV_WR_LINE2: cover property (wr && idx == 6'h17);
   COV_BOTH_CONN: cover property (second_right_line_input_conn_o
                                  && first_left_line_input_conn_o);
   COV_DIFF: cover property (second_right_line_input_diff_o);
   COV_PWR_UP: cover property ($rose(right_adc_power_o));
endmodule // rairr_regs

// ---- sim/testbench.sv ----
// self-checking bench for the right adc input routing register bank
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
   logic [7:0]  adr_i;
   logic [31:0] dat_i, dat_o;
   logic [3:0]  sel_i;
   logic        l2_diff, l2_conn, l1_diff, l1_conn, bias, power;
   logic [4:0]  l2_att, l1_att;
   logic [31:0] exp_q[$];
   logic [31:0] seed;
   int          err_total, check_count;
   rairr_regs dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
      .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
      .second_right_line_input_diff_o(l2_diff),
      .second_right_line_input_conn_o(l2_conn),
      .second_right_line_input_atten_o(l2_att),
      .first_left_line_input_diff_o(l1_diff),
      .first_left_line_input_conn_o(l1_conn),
      .first_left_line_input_atten_o(l1_att),
      .weak_cm_bias_o(bias), .right_adc_power_o(power));
   // free-running 50 mhz clock
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // classic cycle, entered just after a rising edge
   task automatic wb(input logic [7:0] a, input logic [31:0] d,
                     input logic w, input logic [3:0] s);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      adr_i <= a;
      dat_i <= d;
      we_i  <= w;
      sel_i <= s;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         err_total++;
         results();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(a, 32'h0, 1'b0, 4'hf);
   endtask
   // read data is judged where ack shows, against the oldest note
   always @(posedge clk_i)
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
         check("rdata", dat_o, exp_q.pop_front());
   // hang guard
   initial
   begin
      repeat (50000) @(posedge clk_i);
      err_total++;
      results();
   end
   initial
   begin
      logic [7:0]  a2, a1, ap, ad;
      logic [31:0] d, r;
      logic [3:0]  c;
      logic        exp_bias;
      logic [7:0]  l2v;
      a2 = {rairr_pkg::IDX_LINE2, 2'b00};
      a1 = {rairr_pkg::IDX_LINE1, 2'b00};
      ap = {rairr_pkg::IDX_PWR, 2'b00};
      seed = 32'hda8f9121;
      err_total = 0;
      check_count = 0;
      {rst_i, we_i, cyc_i, stb_i} = 4'h8;
      adr_i = 8'h00;
      dat_i = 32'h0;
      sel_i = 4'h0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      // sample settled outputs mid-cycle, drive again on a rising edge
      @(negedge clk_i);
      // reset state: single-ended, disconnected, unbiased
      check("rst_out", {l2_diff, l2_conn, l2_att, l1_diff, l1_conn, l1_att,
                        bias, power}, 32'h0);
      @(posedge clk_i);
      rd(a2, 32'h78);
      rd(a1, 32'h78);
      $display("test reset done");
      exp_bias = 1'b0;
      // every legal level code on both inputs, random side bits
      for (int k = 0; k < 20; k++)
      begin
         // reserved level codes are never written
         c = (k % 10 == 9) ? 4'hf : 4'(k % 10);
         r = xs();
         // reserved low bits written as zeros; bias bit only on line2
         d = {r[31:8], r[7], c, (k < 10) ? r[2] : 1'b0, 2'b00};
         // each input here feeds only the right mixer: no twin diff bit
         ad = (k < 10) ? a2 : a1;
         wb(ad, d, 1'b1, 4'hf);
         if (k < 10)
         begin
            exp_bias = d[2];
            l2v = d[7:0] & rairr_pkg::MASK_LINE2;
            rd(ad, {24'h0, l2v});
         end
         else
            rd(ad, {24'h0, d[7:0] & rairr_pkg::MASK_LINE1});
         @(negedge clk_i);
         if (k < 10)
            check("l2_out", {l2_diff, l2_conn, l2_att},
                  {d[7], c <= 4'h8, (c <= 4'h8) ? 5'(c * 3) : 5'h0});
         else
            check("l1_out", {l1_diff, l1_conn, l1_att},
                  {d[7], c <= 4'h8, (c <= 4'h8) ? 5'(c * 3) : 5'h0});
         check("bias", bias, exp_bias);
         @(posedge clk_i);
      end
      $display("test level codes done");
      // byte lane 0 off: write dropped
      wb(a2, 32'h0, 1'b1, 4'he);
      rd(a2, {24'h0, l2v});
      wb(a2, 32'h7b, 1'b1, 4'h1);
      rd(a2, 32'h78);
      wb(8'h00, xs(), 1'b1, 4'hf);
      rd(8'h00, 32'h0);
      $display("test lanes and unmapped done");
      // right channel power bit
      wb(ap, 32'hff, 1'b1, 4'hf);
      rd(ap, {24'h0, rairr_pkg::MASK_PWR});
      @(negedge clk_i);
      check("power_on", power, 1'b1);
      @(posedge clk_i);
      // status: both inputs disconnected, channel powered
      rd({rairr_pkg::IDX_STAT, 2'b00}, 32'h4);
      wb(ap, 32'h0, 1'b1, 4'hf);
      @(posedge clk_i);
      #1;
      check("power_off", power, 1'b0);
      $display("test power done");
      repeat (4) @(posedge clk_i);
      results();
   end
endmodule // testbench
